// file: rtl/tec_top.sv
// three timer/event counters with their control and preload registers on APB
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "tec_defines.svh"
module tec_top (
    input  wire logic         CORE_CLK,
    input  wire logic         NRST,
    input  wire logic         PSEL,
    input  wire logic         PENABLE,
    input  wire logic         PWRITE,
    input  wire logic [7:0]   PADDR,
    input  wire logic [31:0]  PWDATA,
    output logic     [31:0]   PRDATA,
    output logic              PREADY,
    output logic              PSLVERR,
    input  wire logic         FIRST_COUNT_INPUT_PIN,
    input  wire logic         SECOND_COUNT_INPUT_PIN,
    input  wire logic         THIRD_COUNT_INPUT_PIN,
    input  wire logic         OSC_32K,
    output logic     [2:0]    OVERFLOW_FLAG
);
    typedef struct packed {
        logic [3:0]        sync1;
        logic [3:0]        sync2;
        logic              osc_prev;
        logic [6:0]        pres;
        logic [2:0][7:0]   ctrl;
        logic [2:0][15:0]  preload;
        logic [1:0][7:0]   low_buf;
        logic [2:0]        pre_wr;
        logic [31:0]       rdata;
        logic              ready;
        logic              err;
        logic [2:0]        ovf;
    } state_t;

    state_t            s_q;
    state_t            s_d;
    logic [1:0]        rst_sync_q;
    logic              rst_n;
    logic [2:0][15:0]  count;
    logic [2:0]        ovf;
    logic [2:0]        done;
    logic [2:0]        tick;
    logic [2:0]        pin_s;
    logic [5:0]        idx;
    logic              setup;
    logic              commit;
    logic              osc_tick;
    logic [7:0]        wbyte;

    // reset release through two flops
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign idx    = PADDR[7:2];
    assign setup  = PSEL & ~PENABLE;
    assign commit = PSEL & PENABLE & s_q.ready;
    assign wbyte  = PWDATA[7:0];
    assign pin_s  = s_q.sync2[2:0];
    assign osc_tick = s_q.sync2[3] & ~s_q.osc_prev;

    function automatic logic psc_tick(input logic [6:0] pres,
                                      input logic [2:0] psc);
        logic [7:0] m;
        m = (8'h01 << psc) - 8'h01;
        return (pres & m[6:0]) == m[6:0];
    endfunction

    assign tick[0] = psc_tick(s_q.pres, s_q.ctrl[0][2:0]);
    assign tick[1] = s_q.ctrl[1][`BIT_SRC] ? osc_tick
                   : ((s_q.pres & `DIV4_MASK) == `DIV4_MASK);
    assign tick[2] = psc_tick(s_q.pres, s_q.ctrl[2][2:0]);

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_cnt
            tec_counter #(
                .TOP_VAL (i == 2 ? `TOP_NARROW : `TOP_WIDE)
            ) u_cnt (
                .clk        (CORE_CLK),
                .rst_n      (rst_n),
                .mode       (s_q.ctrl[i][`MODE_HI:`MODE_LO]),
                .edge_sel   (s_q.ctrl[i][`BIT_EDGE]),
                .run        (s_q.ctrl[i][`BIT_RUN]),
                .pin        (pin_s[i]),
                .int_tick   (tick[i]),
                .preload    (s_q.preload[i]),
                .preload_wr (s_q.pre_wr[i]),
                .count      (count[i]),
                .ovf        (ovf[i]),
                .meas_done  (done[i])
            );
        end
    endgenerate

    always_comb begin
        s_d          = s_q;
        s_d.sync1    = {OSC_32K, THIRD_COUNT_INPUT_PIN,
                        SECOND_COUNT_INPUT_PIN, FIRST_COUNT_INPUT_PIN};
        s_d.sync2    = s_q.sync1;
        s_d.osc_prev = s_q.sync2[3];
        s_d.pres     = s_q.pres + 7'h01;
        s_d.ovf      = ovf;
        s_d.pre_wr   = 3'b000;
        s_d.ready    = setup;
        // error stands only in the access cycle, together with ready
        s_d.err      = 1'b0;
        for (int k = 0; k < 3; k++) begin
            if (done[k]) begin
                s_d.ctrl[k][`BIT_RUN] = 1'b0;
            end
        end
        // read data and error are prepared in the setup cycle
        if (setup) begin
            s_d.rdata = 32'h0000_0000;
            s_d.err   = (PADDR[1:0] != 2'h0);
            case (idx)
                `IDX_CNT0_HIGH:   s_d.rdata[7:0] = count[0][15:8];
                `IDX_CNT0_LOW:    s_d.rdata[7:0] = s_q.low_buf[0];
                `IDX_FIRST_CTRL:  s_d.rdata[7:0] = s_q.ctrl[0];
                `IDX_CNT1_HIGH:   s_d.rdata[7:0] = count[1][15:8];
                `IDX_CNT1_LOW:    s_d.rdata[7:0] = s_q.low_buf[1];
                `IDX_SECOND_CTRL: s_d.rdata[7:0] = s_q.ctrl[1];
                `IDX_CNT2:        s_d.rdata[7:0] = count[2][7:0];
                `IDX_THIRD_CTRL:  s_d.rdata[7:0] = s_q.ctrl[2];
                default:          s_d.err = 1'b1;
            endcase
        end
        if (commit && !s_q.err) begin
            if (PWRITE) begin
                case (idx)
                    `IDX_CNT0_LOW: begin
                        s_d.low_buf[0] = wbyte;
                    end
                    `IDX_CNT0_HIGH: begin
                        s_d.preload[0] = {wbyte, s_q.low_buf[0]};
                        s_d.pre_wr[0]  = 1'b1;
                    end
                    `IDX_CNT1_LOW: begin
                        s_d.low_buf[1] = wbyte;
                    end
                    `IDX_CNT1_HIGH: begin
                        s_d.preload[1] = {wbyte, s_q.low_buf[1]};
                        s_d.pre_wr[1]  = 1'b1;
                    end
                    `IDX_CNT2: begin
                        s_d.preload[2] = {8'h00, wbyte};
                        s_d.pre_wr[2]  = 1'b1;
                    end
                    `IDX_FIRST_CTRL: begin
                        s_d.ctrl[0] = wbyte & `CTRL_MASK_PSC;
                    end
                    `IDX_SECOND_CTRL: begin
                        s_d.ctrl[1] = wbyte & `CTRL_MASK_SRC;
                    end
                    `IDX_THIRD_CTRL: begin
                        s_d.ctrl[2] = wbyte & `CTRL_MASK_PSC;
                    end
                    default: begin
                        s_d.err = 1'b0;
                    end
                endcase
            end else begin
                // high byte read latches the low count byte
                case (idx)
                    `IDX_CNT0_HIGH: s_d.low_buf[0] = count[0][7:0];
                    `IDX_CNT1_HIGH: s_d.low_buf[1] = count[1][7:0];
                    default:        s_d.err = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{sync1: 4'h0, sync2: 4'h0, osc_prev: 1'b0,
                     pres: 7'h00,
                     ctrl: {`CTRL_RESET, `CTRL_RESET, `CTRL_RESET},
                     preload: {16'h0000, 16'h0000, 16'h0000},
                     low_buf: {8'h00, 8'h00}, pre_wr: 3'b000,
                     rdata: 32'h0000_0000, ready: 1'b0, err: 1'b0,
                     ovf: 3'b000};
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA        = s_q.rdata;
    assign PREADY        = s_q.ready;
    assign PSLVERR       = s_q.err;
    assign OVERFLOW_FLAG = s_q.ovf;
endmodule
`default_nettype wire

// file: rtl/tec_defines.svh
// constants for the three timer/event counters and their register map
// Summary of operation
// - counters 0 and 2 divide the system clock by two to the power of control bits 2:0, from 1 up to 128.
// - in event count mode the edge bit makes the counter advance on falling pin edges when set, rising when clear.
// - in pulse width mode the edge bit set starts on a rising edge and stops on falling; clear does the reverse.
// - control bit 4 is the run enable, 1 counts and 0 stops.
// - unused control bits read as zero: bit 5 of counters 0 and 2, bits 2:0 of counter 1.
// - counter 1 control bit 5 picks the system clock over four when 0, the 32768Hz oscillator when 1.
// - mode bits 7:6 give event count at 01, timer at 10, pulse width at 11, and 00 is unused.
// - counters count up to all ones, then reload from the preload and raise an overflow flag.
// - pulse width mode clears the run enable after one measurement; otherwise only software clears it.
// - on a 16-bit counter a low byte write fills a buffer and the high byte write moves both into the preload.
// - a preload write while stopped also loads the counter; while running it waits for the next overflow.
`ifndef TEC_DEFINES_SVH
`define TEC_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_CNT0_HIGH    6'h0C
`define IDX_CNT0_LOW     6'h0D
`define IDX_FIRST_CTRL   6'h0E
`define IDX_CNT1_HIGH    6'h0F
`define IDX_CNT1_LOW     6'h10
`define IDX_SECOND_CTRL  6'h11
`define IDX_CNT2         6'h2D
`define IDX_THIRD_CTRL   6'h2E

`define CTRL_RESET       8'h00
`define CTRL_MASK_PSC    8'hDF
`define CTRL_MASK_SRC    8'hF8
`define BIT_EDGE         3
`define BIT_RUN          4
`define BIT_SRC          5
`define MODE_HI          7
`define MODE_LO          6

`define TOP_WIDE         16'hFFFF
`define TOP_NARROW       16'h00FF
`define DIV4_MASK        7'h03
`define OSC_HZ           32768

`endif

// file: rtl/tec_pkg.sv
// types shared by the timer/event counter block
package tec_pkg;
    typedef enum logic [1:0] {
        MODE_UNUSED = 2'h0,
        MODE_EVENT  = 2'h1,
        MODE_TIMER  = 2'h2,
        MODE_PULSE  = 2'h3
    } mode_t;

    typedef enum logic [1:0] {
        MEAS_WAIT = 2'b01,
        MEAS_RUN  = 2'b10
    } meas_t;
endpackage

// file: rtl/tec_counter.sv
// one count-up timer/event counter with reload and pulse width capture
`timescale 1ns/10ps
`default_nettype none
module tec_counter #(
    parameter logic [15:0] TOP_VAL = 16'hFFFF
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [1:0]   mode,
    input  wire logic         edge_sel,
    input  wire logic         run,
    input  wire logic         pin,
    input  wire logic         int_tick,
    input  wire logic [15:0]  preload,
    input  wire logic         preload_wr,
    output logic     [15:0]   count,
    output logic              ovf,
    output logic              meas_done
);
    typedef struct packed {
        logic [15:0]   cnt;
        logic          pin_prev;
        tec_pkg::meas_t meas;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic   rise;
    logic   fall;
    logic   adv;
    logic   start_e;
    logic   stop_e;

    assign rise      = pin & ~s_q.pin_prev;
    assign fall      = ~pin & s_q.pin_prev;
    assign start_e   = edge_sel ? rise : fall;
    assign stop_e    = edge_sel ? fall : rise;
    assign count     = s_q.cnt;

    always_comb begin
        s_d       = s_q;
        adv       = 1'b0;
        meas_done = 1'b0;
        s_d.pin_prev = pin;
        case (tec_pkg::mode_t'(mode))
            tec_pkg::MODE_EVENT: begin
                adv = run & (edge_sel ? fall : rise);
            end
            tec_pkg::MODE_TIMER: begin
                adv = run & int_tick;
            end
            tec_pkg::MODE_PULSE: begin
                case (s_q.meas)
                    tec_pkg::MEAS_WAIT: begin
                        if (run && start_e) begin
                            s_d.meas = tec_pkg::MEAS_RUN;
                        end
                    end
                    tec_pkg::MEAS_RUN: begin
                        adv = run & int_tick;
                        if (stop_e) begin
                            adv       = 1'b0;
                            meas_done = run;
                            s_d.meas  = tec_pkg::MEAS_WAIT;
                        end
                    end
                    default: begin
                        s_d.meas = tec_pkg::MEAS_WAIT;
                    end
                endcase
            end
            default: begin
                adv = 1'b0;
            end
        endcase
        if (!run) begin
            adv      = 1'b0;
            s_d.meas = tec_pkg::MEAS_WAIT;
        end
        ovf = adv && (s_q.cnt == TOP_VAL);
        if (ovf) begin
            s_d.cnt = preload;
        end else if (adv) begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
        if (preload_wr && !run) begin
            s_d.cnt = preload;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{cnt: 16'h0000, pin_prev: 1'b0,
                     meas: tec_pkg::MEAS_WAIT};
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

// file: testbench/tec_assertions.sv
// checker for bus timing and control read-back of the timer block
`timescale 1ns/10ps
`default_nettype none
`include "tec_defines.svh"
module tec_assertions (
    input wire logic        CORE_CLK,
    input wire logic        NRST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        FIRST_COUNT_INPUT_PIN,
    input wire logic        SECOND_COUNT_INPUT_PIN,
    input wire logic        THIRD_COUNT_INPUT_PIN,
    input wire logic        OSC_32K,
    input wire logic [2:0]  OVERFLOW_FLAG
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    sequence setup_s;
        PSEL && !PENABLE;
    endsequence
    sequence rd_s(a);
        PREADY && !PWRITE && PADDR == a;
    endsequence
    a_ready_after_setup: assert property (setup_s |=> PREADY)
        else $error("ready missing after setup");
    a_ready_one_cycle: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access");
    a_err_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_err_bad_align: assert property (PREADY && PADDR[1:0] != 2'h0
        |-> PSLVERR) else $error("misaligned access accepted");
    a_upper_zero: assert property (PREADY && !PWRITE
        |-> PRDATA[31:8] == 24'h0) else $error("read data upper bits set");
    a_unused_first: assert property (
        rd_s({`IDX_FIRST_CTRL, 2'h0}) |-> !PRDATA[5])
        else $error("first control bit 5 set");
    a_unused_second: assert property (
        rd_s({`IDX_SECOND_CTRL, 2'h0}) |-> PRDATA[2:0] == 3'h0)
        else $error("second control low bits set");
    a_unused_third: assert property (
        rd_s({`IDX_THIRD_CTRL, 2'h0}) |-> !PRDATA[5])
        else $error("third control bit 5 set");
    a_flags_reset: assert property (disable iff (1'b0)
        !NRST ##1 !NRST |-> OVERFLOW_FLAG == 3'h0)
        else $error("flag during reset");
endmodule
`default_nettype wire

// file: testbench/tec_pin_model.sv
// far-side model: counter input pins and slow oscillator
`timescale 1ns/10ps
`default_nettype none
module tec_pin_model #(
    parameter int HALF = 20
) (
    input  wire logic       clk,
    output logic     [2:0]  pin,
    output logic            osc
);
    initial begin
        pin = 3'h0;
        osc = 1'b0;
    end
    // oscillator scaled down so several periods fit the run
    always begin
        repeat (HALF) @(posedge clk);
        osc <= ~osc;
    end
    // one pin transition, then held for w cycles
    task automatic flip(input int i, input int w);
        @(posedge clk);
        pin[i] <= ~pin[i];
        repeat (w) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: testbench/tec_top_tb_top.sv
// self-checking bench for the timer/event counter block
`timescale 1ns/10ps
`default_nettype none
`include "tec_defines.svh"
module tec_top_tb_top;
    localparam int HALF = 20;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  pin;
    logic [2:0]  flag;
    logic        osc;
    logic [31:0] rdata;
    logic        serr;
    int          mismatches = 0;
    int          cmp_count = 0;
    logic [5:0]  cix [3] = '{`IDX_FIRST_CTRL, `IDX_SECOND_CTRL,
                             `IDX_THIRD_CTRL};
    logic [5:0]  hix [3] = '{`IDX_CNT0_HIGH, `IDX_CNT1_HIGH, `IDX_CNT2};
    logic [7:0]  msk [3] = '{`CTRL_MASK_PSC, `CTRL_MASK_SRC,
                             `CTRL_MASK_PSC};
    always #5 clk = ~clk;
    tec_top i_tec_top (.CORE_CLK(clk), .NRST(nrst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .FIRST_COUNT_INPUT_PIN(pin[0]),
        .SECOND_COUNT_INPUT_PIN(pin[1]), .THIRD_COUNT_INPUT_PIN(pin[2]),
        .OSC_32K(osc), .OVERFLOW_FLAG(flag));
    tec_pin_model #(.HALF(HALF)) i_tec_pin_model (.clk(clk), .pin(pin),
        .osc(osc));
    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        // pready, read data and error are taken at the rising edge only
        do @(posedge clk); while (pready !== 1'b1 && ++k < 50);
        if (k >= 50) begin
            mismatches++;
            summarize();
        end
        rdata = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [5:0] x, input logic [7:0] d);
        apb(1'b1, {x, 2'h0}, d);
    endtask
    task rd(input logic [5:0] x);
        apb(1'b0, {x, 2'h0}, 8'h00);
    endtask
    task setpre(input int i, input logic [15:0] v);
        if (i < 2) begin
            wr(hix[i] + 6'h1, v[7:0]);
        end
        wr(hix[i], (i < 2) ? v[15:8] : v[7:0]);
    endtask
    task rdcnt(input int i, output logic [15:0] c);
        rd(hix[i]);
        c = {8'h00, rdata[7:0]};
        if (i < 2) begin
            rd(hix[i] + 6'h1);
            c = {c[7:0], rdata[7:0]};
        end
    endtask
    // cycles between two overflow pulses
    task per(input int i, input int e);
        int n;
        n = 0;
        do @(negedge clk); while (flag[i] !== 1'b1 && ++n < 3000);
        n = 0;
        do @(negedge clk); while (flag[i] !== 1'b1 && ++n < 3000);
        chk("overflow period", e, n + 1);
    endtask
    initial begin
        logic [15:0] c;
        logic [15:0] w;
        logic [7:0]  v;
        int          e;
        v = $urandom(92092);
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            rd(cix[i]);
            chk("control reset", 32'h0, rdata);
            repeat (4) begin
                v = $urandom;
                wr(cix[i], v);
                rd(cix[i]);
                chk("control", {24'h0, v & msk[i]}, rdata);
            end
            wr(cix[i], 8'h00);
        end
        apb(1'b0, 8'h00, 8'h00);
        chk("unmapped error", 32'h1, {31'h0, serr});
        apb(1'b1, {`IDX_THIRD_CTRL, 2'h1}, 8'h90);
        chk("misaligned error", 32'h1, {31'h0, serr});
        rd(`IDX_THIRD_CTRL);
        chk("refused write", 32'h0, rdata);
        for (int p = 0; p < 8; p++) begin
            for (int i = 0; i < 3; i += 2) begin
                setpre(i, 16'hFFFE);
                wr(cix[i], 8'h90 | p[7:0]);
                per(i, 2 << p);
                wr(cix[i], 8'h00);
            end
        end
        setpre(1, 16'hFFFE);
        wr(cix[1], 8'h90);
        per(1, 8);
        wr(cix[1], 8'hB0);
        per(1, 4 * HALF);
        wr(cix[1], 8'h00);
        // a lone low byte must leave the loaded count alone
        c = $urandom;
        setpre(1, c);
        wr(hix[1] + 6'h1, ~c[7:0]);
        rdcnt(1, w);
        chk("paired preload", c, w);
        for (e = 0; e < 2; e++) begin
            setpre(1, 16'h0000);
            wr(cix[1], 8'h50 | (e[7:0] << 3));
            repeat (7) i_tec_pin_model.flip(1, 4);
            wr(cix[1], 8'h40 | (e[7:0] << 3));
            i_tec_pin_model.flip(1, 4);
            rdcnt(1, c);
            chk("event count", e ? 3 : 4, c);
        end
        for (e = 0; e < 2; e++) begin
            if (e == 0) i_tec_pin_model.flip(2, 4);
            setpre(2, 16'h0000);
            wr(cix[2], 8'hD0 | (e[7:0] << 3));
            i_tec_pin_model.flip(2, 20);
            i_tec_pin_model.flip(2, 6);
            rd(cix[2]);
            chk("run cleared", 8'hC0 | (e[7:0] << 3), rdata);
            rdcnt(2, c);
            chk("pulse width", 1, c >= 19 && c <= 21);
            i_tec_pin_model.flip(2, 20);
            i_tec_pin_model.flip(2, 6);
            rdcnt(2, w);
            chk("single shot", c, w);
            if (e == 0) i_tec_pin_model.flip(2, 4);
        end
        summarize();
    end
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        summarize();
    end
endmodule
bind tec_top tec_assertions i_tec_assertions (.CORE_CLK(CORE_CLK),
    .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FIRST_COUNT_INPUT_PIN(FIRST_COUNT_INPUT_PIN),
    .SECOND_COUNT_INPUT_PIN(SECOND_COUNT_INPUT_PIN),
    .THIRD_COUNT_INPUT_PIN(THIRD_COUNT_INPUT_PIN), .OSC_32K(OSC_32K),
    .OVERFLOW_FLAG(OVERFLOW_FLAG));
`default_nettype wire
